// *** src/burst_step.sv ***
// Burst address sequencer for the two low address bits.
// Assumes the count is the access number within the burst.
`timescale 1ns/1ns
module burst_step
   import sram_port_pkg::*;
#(
   parameter int BITS = BURST_BITS
) (
   input wire logic [BITS-1:0] base, // Low bits of the loaded address
   input wire logic [BITS-1:0] count, // Access number in the burst
   input wire logic interleave, // High selects interleaved order
   output logic [BITS-1:0] step // Low bits of this access
);

   // Linear adds and wraps, interleaved flips bits by the count
   assign step = interleave ? (base ^ count) : BITS'(base + count);

endmodule // burst_step

// *** src/pipelined_burst_sram_port.sv ***
// Pipelined burst static memory port with byte lane writes.
// Assumes all inputs synchronous to clk except output enable and reset,
// and a controller that deselects the part before sleeping.
`timescale 1ns/1ns
module pipelined_burst_sram_port
   import sram_port_pkg::*;
#(
   parameter int LANES = DEFAULT_LANES,
   parameter int ADDR_W = DEFAULT_ADDR_W,
   parameter int FIFO_DEPTH = READ_FIFO_DEPTH
) (
   input wire logic clk, // System clock, 125 MHz
   input wire logic rstn, // Reset, active low, asynchronous
   input wire logic [ADDR_W-1:0] address, // External word address
   input wire logic chip_sel1_n, // First chip select, active low
   input wire logic chip_sel2, // Second chip select, active high
   input wire logic chip_sel3_n, // Third chip select, active low
   input wire logic advance_load, // High advances, low loads
   input wire logic write_n, // Write strobe, active low
   input wire logic [LANES-1:0] byte_lane_select_n, // Lane selects, active low
   input wire logic clock_qualifier_n, // Edge qualifier, active low
   input wire logic output_enable_n, // Output enable, active low
   input wire logic sleep_request, // Sleep request, active high
   input wire logic burst_order, // Low linear, high interleaved
   input wire logic [LANES*LANE_BITS-1:0] dq_in, // Data pins in
   input wire logic [LANES-1:0] parity_lane_in, // Parity pins in
   output logic [LANES*LANE_BITS-1:0] dq_out, // Data pins out
   output logic [LANES-1:0] parity_lane_out, // Parity pins out
   output logic dq_oe, // Drive data pins, high drives
   output logic parity_lane_oe // Drive parity pins, high drives
);

   localparam int WORD_W = LANES * LANE_WORD;
   localparam int DEPTH = 2 ** ADDR_W;

   logic rst_meta_n; // First reset synchroniser stage
   logic rst_sync_n; // Released reset used everywhere
   logic chips_on; // All three selects active
   logic go; // Edge qualified by the pins
   logic en; // Edge acted upon
   logic fifo_in_ready; // Read buffer has room
   logic fifo_out_valid; // Read buffer holds a word
   logic [WORD_W-1:0] fifo_out; // Oldest buffered read word
   logic [WORD_W-1:0] array_word; // Array contents at this address
   logic [WORD_W-1:0] write_word; // Pin data packed per lane
   op_type kind; // Operation of the running burst
   op_type next_op; // Operation issued at this edge
   logic [ADDR_W-1:0] base; // Address loaded at burst start
   logic [BURST_BITS-1:0] count; // Access number in the burst
   logic [BURST_BITS-1:0] next_count; // Access number after this edge
   logic [BURST_BITS-1:0] low_bits; // Sequenced low address bits
   logic [ADDR_W-1:0] cur_addr; // Address used at this edge
   logic loading; // Load cycle at this edge
   op_type op1; // Operation one edge old
   logic [ADDR_W-1:0] addr1; // Its address
   logic [LANES-1:0] mask1; // Its write lanes
   op_type op2; // Operation in its data phase
   logic [ADDR_W-1:0] addr2; // Its address
   logic [LANES-1:0] mask2; // Its write lanes
   logic [WORD_W-1:0] rdata; // Output register

   // Reset release through two flops; only the second is read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // Qualifier and sleep gate every edge; a full buffer stalls too
   assign chips_on = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
   assign go = !clock_qualifier_n && !sleep_request;
   assign en = go && fifo_in_ready;
   assign loading = !advance_load;

   // Decode of the operation entering the pipeline
   always_comb begin
      next_op = OP_IDLE;
      if (loading) begin
         // Write strobe alone decides the type; lanes only qualify
         if (chips_on) begin
            next_op = write_n ? OP_READ : OP_WRITE;
         end else begin
            next_op = OP_IDLE;
         end
      end else begin
         // Continue keeps the burst type, selects and strobe ignored
         next_op = kind;
      end
   end

   // Next access number; a load restarts at the loaded address
   assign next_count = loading ? BURST_RESET : BURST_BITS'(count + BURST_INC);

   // Burst sequencer for the low address bits
   burst_step #(
      .BITS(BURST_BITS)
   ) u_step (
      .base(base[BURST_BITS-1:0]),
      .count(next_count),
      .interleave(burst_order),
      .step(low_bits)
   );

   // Address of this access: pins on load, sequenced otherwise
   assign cur_addr = loading ? address : {base[ADDR_W-1:BURST_BITS], low_bits};

   // Burst state; a deselect clears the type so continues stay idle
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         kind <= OP_IDLE;
         base <= '0;
         count <= BURST_RESET;
      end else if (sleep_request) begin
         kind <= OP_IDLE;
         count <= BURST_RESET;
      end else if (en) begin
         if (loading) begin
            kind <= next_op;
            base <= address;
         end
         count <= next_count;
      end
   end

   // Per-lane storage; each lane writes on its own select
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      logic [LANE_WORD-1:0] lane_mem [DEPTH]; // Lane data and parity
      assign write_word[i*LANE_WORD +: LANE_WORD] = {parity_lane_in[i], dq_in[i*LANE_BITS +: LANE_BITS]};
      assign array_word[i*LANE_WORD +: LANE_WORD] = lane_mem[cur_addr];
      // Data phase ends at the second edge after the address
      always_ff @(posedge clk) begin
         if (en && op2 == OP_WRITE && mask2[i]) begin
            // Sleep drops en, so stored words survive it untouched
            lane_mem[addr2] <= write_word[i*LANE_WORD +: LANE_WORD];
         end
      end
      assign dq_out[i*LANE_BITS +: LANE_BITS] = rdata[i*LANE_WORD +: LANE_BITS];
      assign parity_lane_out[i] = rdata[i*LANE_WORD + LANE_BITS];
   end

   // Read words wait here between array and output register.
   // Pushes and pops pair up, so it never holds more than one word
   // unless sleep drops a buffered read in flight; a full buffer stalls the whole port.
   word_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_read_fifo (
      .clk(clk),
      .rst_n(rst_sync_n),
      .in_valid(go && next_op == OP_READ),
      .in_ready(fifo_in_ready),
      .in_data(array_word),
      .out_valid(fifo_out_valid),
      .out_ready(en && op1 == OP_READ),
      .out_data(fifo_out)
   );

   // Address pipeline; sleep drops accesses in flight
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         op1 <= OP_IDLE;
         addr1 <= '0;
         mask1 <= '0;
         op2 <= OP_IDLE;
         addr2 <= '0;
         mask2 <= '0;
      end else if (sleep_request) begin
         op1 <= OP_IDLE;
         op2 <= OP_IDLE;
      end else if (en) begin
         op1 <= next_op;
         addr1 <= cur_addr;
         // Lanes sampled with each write address, none for reads
         mask1 <= (next_op == OP_WRITE) ? ~byte_lane_select_n : '0;
         op2 <= op1;
         addr2 <= addr1;
         mask2 <= mask1;
      end
   end

   // Output register loads one edge after the array access
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata <= '0;
      end else if (en && op1 == OP_READ && fifo_out_valid) begin
         rdata <= fifo_out;
      end
   end

   // Drivers follow the data-phase operation and enable without a clock;
   // a write in its data phase never drives, whatever the enable does
   assign dq_oe = (op2 == OP_READ) && !output_enable_n && !sleep_request;
   assign parity_lane_oe = dq_oe;

   // Checks of the port behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_sync_n);

   logic start_read; // Begin-read accepted
   logic start_write; // Begin-write accepted
   assign start_read = en && loading && chips_on && write_n;
   assign start_write = en && loading && chips_on && !write_n;

   // Drive appears after the second accepted edge, so look one edge later
   read_latency_a: assert property (start_read ##1 en |=> (output_enable_n || sleep_request || dq_oe))
      else $error("read data not driven one edge after begin-read");
   read_pipe_a: assert property (start_read |=> (op1 == OP_READ) ##1 (op2 == OP_READ || !$past(en)))
      else $error("read did not reach data phase");
   // An earlier read may still own the pins one edge after the write address
   write_quiet_a: assert property (start_write ##1 en |=> !dq_oe && !parity_lane_oe)
      else $error("pins driven during write data phase");
   oe_mask_a: assert property ((op2 == OP_WRITE && !output_enable_n) |-> !dq_oe && !parity_lane_oe)
      else $error("output enable not masked during write");
   oe_off_a: assert property ((op2 == OP_READ && output_enable_n) |-> !dq_oe)
      else $error("dummy read drove the pins");
   stall_hold_a: assert property ((clock_qualifier_n && !sleep_request) |=> $stable(op2) && $stable(rdata)
      && $stable(count))
      else $error("stalled edge changed state");
   burst_step_a: assert property ((en && advance_load && kind != OP_IDLE) |=>
      count == BURST_BITS'($past(count) + BURST_INC) && op1 == $past(kind))
      else $error("burst counter did not advance");
   deselect_a: assert property ((en && loading && !chips_on) |=> op1 == OP_IDLE ##1 (!$past(en) || !dq_oe))
      else $error("deselect did not tristate");
   abort_a: assert property (start_write && (&byte_lane_select_n) |=> mask1 == '0 ##1 (!$past(en) || !dq_oe))
      else $error("write abort selected lanes");
   sleep_a: assert property (sleep_request |-> !dq_oe ##1 (op1 == OP_IDLE && op2 == OP_IDLE))
      else $error("sleep left pins driven or accesses pending");
   reset_quiet_a: assert property ($rose(rst_sync_n) |-> !dq_oe && op2 == OP_IDLE)
      else $error("not deselected after reset");

   burst_read_c: cover property (start_read ##1 (en && advance_load) [*3]);
   turn_c: cover property (start_write ##1 start_read ##1 en ##1 dq_oe);
   stall_c: cover property ((kind == OP_READ) ##1 clock_qualifier_n [*2] ##1 en);
   sleep_c: cover property (sleep_request ##1 !sleep_request ##2 start_read);

endmodule // pipelined_burst_sram_port

// *** src/sram_port_pkg.sv ***
// Shared constants and types for the pipelined burst memory port.
// Assumes one rising-edge clock domain and active-low chip controls except the active-high second select.
package sram_port_pkg;

   // Bits of data in one byte lane, beside its single parity bit
   localparam int LANE_BITS = 8;
   // Data plus parity bits stored per lane
   localparam int LANE_WORD = LANE_BITS + 1;
   // Wide variant has four lanes, narrow variant two
   localparam int DEFAULT_LANES = 4;
   // Word address width of the wide variant
   localparam int DEFAULT_ADDR_W = 20;
   // Read data buffer depth in words
   localparam int READ_FIFO_DEPTH = 16;
   // Low address bits stepped by the burst counter
   localparam int BURST_BITS = 2;
   // Burst counter value after reset and at each load
   localparam logic [1:0] BURST_RESET = 2'h0;
   // Burst counter increment
   localparam logic [1:0] BURST_INC = 2'h1;

   // Operation carried in the pipeline; idle also marks a deselect
   typedef enum logic [1:0] {
      OP_IDLE  = 2'b00,
      OP_READ  = 2'b01,
      OP_WRITE = 2'b10
   } op_type;

endpackage

// *** src/word_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides.
// Assumes a power of two depth and one clock for both sides.
`timescale 1ns/1ns
module word_fifo
   import sram_port_pkg::*;
#(
   parameter int WIDTH = 36,
   parameter int DEPTH = READ_FIFO_DEPTH
) (
   input wire logic clk, // System clock
   input wire logic rst_n, // Synchronised reset, active low
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word to store
   output logic out_valid, // Word available
   input wire logic out_ready, // Drain takes the word
   output logic [WIDTH-1:0] out_data // Oldest word
);

   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH]; // Word storage
   logic [PTR_W-1:0] wr_ptr; // Next slot to fill
   logic [PTR_W-1:0] rd_ptr; // Oldest slot
   logic [PTR_W:0] fill; // Words held
   logic push; // Word enters this cycle
   logic pop; // Word leaves this cycle

   // Full and empty come straight from the fill count
   assign in_ready = (fill != (PTR_W+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = store[rd_ptr];

   // Storage has no reset; only the pointers and fill count need one
   always_ff @(posedge clk) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end else begin
         if (push) begin
            wr_ptr <= PTR_W'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= PTR_W'(rd_ptr + 1'b1);
         end
         if (push && !pop) begin
            fill <= (PTR_W+1)'(fill + 1'b1);
         end else if (pop && !push) begin
            fill <= (PTR_W+1)'(fill - 1'b1);
         end
      end
   end

endmodule // word_fifo

// *** verif/bus_master_model.sv ***
// Controller model that drives the memory port's synchronous pins.
// Assumes the bench calls issue once a cycle, 1 ns after a rising edge.
`timescale 1ns/1ns
module bus_master_model
   import sram_port_pkg::*;
#(
   parameter int LANES = DEFAULT_LANES,
   parameter int ADDR_W = DEFAULT_ADDR_W
) (
   input wire logic clk, // System clock
   output logic [ADDR_W-1:0] address, // Word address
   output logic chip_sel1_n, // First select, active low
   output logic chip_sel2, // Second select, active high
   output logic chip_sel3_n, // Third select, active low
   output logic advance_load, // High advances, low loads
   output logic write_n, // Write strobe, active low
   output logic [LANES-1:0] byte_lane_select_n, // Lane selects, active low
   output logic clock_qualifier_n, // High stalls the edge
   output logic sleep_request, // Sleep, active high
   output logic [LANES*LANE_BITS-1:0] dq_in, // Write data pins
   output logic [LANES-1:0] parity_lane_in // Write parity pins
);
   localparam int W = LANES*LANE_WORD;
   logic [W-1:0] wd0, wd1; // Write data, two stages behind its address
   logic wv0, wv1; // Stage holds real write data
   logic in_write; // Burst in progress is a write
   logic [W-1:0] pins; // Pin levels, parity on top
   assign dq_in = pins[LANES*LANE_BITS-1:0];
   assign parity_lane_in = pins[W-1:LANES*LANE_BITS];

   // Start deselected with nothing in flight
   initial begin
      {wd0, wd1, pins} = '0;
      {wv0, wv1, in_write} = '0;
      address = '0;
      {chip_sel1_n, chip_sel2, chip_sel3_n} = 3'b101;
      {advance_load, write_n, clock_qualifier_n, sleep_request} = 4'b0100;
      byte_lane_select_n = '1;
   end

   // One command a call; selects given as an active-high mask
   task automatic issue(input logic ld, input logic [2:0] sel, input logic wn, input logic [LANES-1:0] ln,
      input logic [ADDR_W-1:0] a, input logic [W-1:0] d, input logic stall, input logic zz);
      address = a;
      advance_load = !ld;
      chip_sel1_n = !sel[0];
      chip_sel2 = sel[1];
      chip_sel3_n = !sel[2];
      write_n = wn;
      byte_lane_select_n = ln;
      clock_qualifier_n = stall;
      sleep_request = zz;
      // Burst kind is fixed at the load only
      if (ld && !stall && !zz)
         in_write = (sel == 3'h7) && !wn;
      wd0 = d;
      wv0 = in_write && !stall && !zz;
      @(posedge clk);
      #1;
   endtask

   // Data goes out two edges after its address; released pins never
   // keep the old value past an unstalled edge, so a stale sample cannot pass by luck
   always @(posedge clk) begin
      if (!clock_qualifier_n) begin
         wd1 <= wd0;
         wv1 <= wv0;
         pins <= #1 (wv1 ? wd1 : ~pins);
      end
   end
endmodule // bus_master_model

// *** verif/tb.sv ***
// Self-checking bench for the pipelined burst memory port.
// Assumes bus_master_model drives the synchronous pins.
`timescale 1ns/1ns
module tb;
   import sram_port_pkg::*;
   localparam int AW = 8; // Small array keeps the run short
   localparam int W = DEFAULT_LANES*LANE_WORD;
   typedef struct {logic [AW-1:0] a; logic [3:0] ln; logic [W-1:0] d; logic [W-1:0] ex;} row_type;
   logic clk, rstn, output_enable_n, burst_order;
   logic [AW-1:0] address;
   logic chip_sel1_n, chip_sel2, chip_sel3_n, advance_load, write_n, clock_qualifier_n, sleep_request;
   logic [3:0] byte_lane_select_n, parity_lane_in, parity_lane_out;
   logic [31:0] dq_in, dq_out;
   logic dq_oe, parity_lane_oe;
   int err_total, samples_checked, cycles;
   logic pchk; // Previous command should show read data now
   logic [W-1:0] pex; // Data that read should show
   // Partial writes over a cleared word: lanes, data, result
   row_type rows [6] = '{
      '{8'h10, 4'hE, 36'hF_FFFF_FFFF, 36'h1_0000_00FF},
      '{8'h11, 4'hD, 36'hF_FFFF_FFFF, 36'h2_0000_FF00},
      '{8'h12, 4'h6, 36'hF_FFFF_FFFF, 36'h9_FF00_00FF},
      '{8'h13, 4'h0, 36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF},
      '{8'h14, 4'hF, 36'hF_FFFF_FFFF, 36'h0_0000_0000},
      '{8'h15, 4'hA, 36'hF_FFFF_FFFF, 36'h5_00FF_00FF}};

   pipelined_burst_sram_port #(.ADDR_W(AW)) dut (.clk(clk), .rstn(rstn), .address(address),
      .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n), .advance_load(advance_load),
      .write_n(write_n), .byte_lane_select_n(byte_lane_select_n), .clock_qualifier_n(clock_qualifier_n),
      .output_enable_n(output_enable_n), .sleep_request(sleep_request), .burst_order(burst_order),
      .dq_in(dq_in), .parity_lane_in(parity_lane_in), .dq_out(dq_out), .parity_lane_out(parity_lane_out),
      .dq_oe(dq_oe), .parity_lane_oe(parity_lane_oe));
   bus_master_model #(.ADDR_W(AW)) ctl (.clk(clk), .address(address), .chip_sel1_n(chip_sel1_n),
      .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n), .advance_load(advance_load), .write_n(write_n),
      .byte_lane_select_n(byte_lane_select_n), .clock_qualifier_n(clock_qualifier_n),
      .sleep_request(sleep_request), .dq_in(dq_in), .parity_lane_in(parity_lane_in));

   // 125 MHz clock
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end

   // Hang guard, well above the hundred or so cycles needed
   initial cycles = 0;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         $display("MISMATCH at %0t: run did not finish", $time);
         tally_and_finish();
      end
   end

   task automatic check(input logic [W-1:0] seen, input logic [W-1:0] want, input string what);
      samples_checked++;
      if (seen !== want) begin
         err_total++;
         $display("MISMATCH at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One command; checks the read issued one call earlier
   task automatic cmd(input logic ld, input logic [2:0] sel, input logic wn, input logic [3:0] ln,
      input logic [AW-1:0] a, input logic [W-1:0] d, input logic chk, input logic [W-1:0] ex, input logic zz);
      ctl.issue(ld, sel, wn, ln, a, d, 1'b0, zz);
      if (pchk)
         check({parity_lane_out, dq_out}, pex, "read data");
      check(W'(dq_oe), W'(pchk && !output_enable_n), "data drive");
      check(W'(parity_lane_oe), W'(pchk && !output_enable_n), "parity drive");
      pchk = chk;
      pex = ex;
   endtask

   task automatic wr(input logic ld, input logic [AW-1:0] a, input logic [3:0] ln, input logic [W-1:0] d);
      cmd(ld, 3'h7, 1'b0, ln, a, d, 1'b0, '0, 1'b0);
   endtask

   // Reads assert every lane select; the port ignores lane selects on reads
   task automatic rd(input logic ld, input logic [AW-1:0] a, input logic [W-1:0] ex);
      cmd(ld, 3'h7, 1'b1, 4'h0, a, '0, 1'b1, ex, 1'b0);
   endtask

   task automatic idle();
      cmd(1'b1, 3'h0, 1'b1, 4'hF, '0, '0, 1'b0, '0, 1'b0);
   endtask

   function automatic logic [W-1:0] pat(input logic [AW-1:0] a, input logic [3:0] s);
      return {a[3:0] ^ s, a ^ {s, s}, ~a, a + {4'h0, s}, a ^ 8'hC3};
   endfunction

   function automatic logic [AW-1:0] baddr(input logic [AW-1:0] b, input int i, input logic il);
      return {b[AW-1:2], il ? (b[1:0] ^ 2'(i)) : (b[1:0] + 2'(i))};
   endfunction

   initial begin
      logic [AW-1:0] b, x;
      rstn = 0;
      output_enable_n = 0;
      burst_order = 0;
      pchk = 0;
      pex = '0;
      err_total = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      #1 rstn = 1;
      repeat (3) @(posedge clk);
      #1;
      check(W'(dq_oe), '0, "drive after reset");
      check({parity_lane_out, dq_out}, '0, "output after reset");
      // Table rows: clear, partial write, read back
      foreach (rows[i]) wr(1, rows[i].a, 4'h0, '0);
      foreach (rows[i]) wr(1, rows[i].a, rows[i].ln, rows[i].d);
      idle();
      idle();
      foreach (rows[i]) rd(1, rows[i].a, rows[i].ex);
      idle();
      // Bursts in both orders; third write beat has no lanes
      for (int il = 0; il < 2; il++) begin
         burst_order = il[0];
         b = il[0] ? 8'h32 : 8'h21;
         for (int i = 0; i < 4; i++) wr(1, baddr(b, i, 0), 4'h0, pat(baddr(b, i, 0), 4'h0));
         for (int i = 0; i < 4; i++)
            wr(i == 0, i == 0 ? b : ~b, i == 2 ? 4'hF : 4'h0, pat(baddr(b, i, il[0]), 4'h5));
         idle();
         idle();
         for (int i = 0; i < 4; i++) begin
            x = baddr(b, i, il[0]);
            rd(1, x, pat(x, i == 2 ? 4'h0 : 4'h5));
         end
         for (int i = 0; i < 4; i++) begin
            x = baddr(b, i, il[0]);
            rd(i == 0, i == 0 ? b : ~b, pat(x, i == 2 ? 4'h0 : 4'h5));
         end
         idle();
      end
      // Each chip select alone deselects; advance keeps it deselected
      for (int k = 0; k < 3; k++) begin
         rd(1, 8'h10, rows[0].ex);
         cmd(1, 3'h7 ^ (3'h1 << k), 1, 4'h0, 8'h11, '0, 0, '0, 0);
         cmd(0, 3'h7, 1, 4'h0, 8'h12, '0, 0, '0, 0);
         idle();
      end
      // Dummy reads with output enable off; interleaved step 13 to 12
      output_enable_n = 1;
      rd(1, 8'h13, rows[3].ex);
      rd(0, 8'h00, rows[2].ex);
      idle();
      output_enable_n = 0;
      // Stalled edge holds the pipeline
      rd(1, 8'h14, rows[4].ex);
      ctl.issue(0, 3'h7, 1, 4'h0, 8'h00, '0, 1, 0);
      ctl.issue(0, 3'h7, 1, 4'h0, 8'h00, '0, 1, 0);
      check({parity_lane_out, dq_out}, rows[2].ex, "stalled output");
      idle();
      // Output enable acts between edges
      output_enable_n = 1;
      #1 check(W'(dq_oe), '0, "enable off");
      output_enable_n = 0;
      #1 check(W'(dq_oe), W'(1'b1), "enable on");
      @(posedge clk);
      #1;
      // Deselect first, then sleep with writes and reads offered
      rd(1, 8'h15, rows[5].ex);
      idle();
      for (int i = 0; i < 4; i++) cmd(1, 3'h7, i[0], 4'h0, 8'h15, '1, 0, '0, 1);
      idle();
      idle();
      rd(1, 8'h15, rows[5].ex);
      idle();
      tally_and_finish();
   end
endmodule // tb
